//--- design/bitslice_alu_source_function.sv
`timescale 1ns/1ns
module bitslice_alu_source_function (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic [slice_pkg::CTRL_W-1:0] ctrl_word_i,
    input wire logic [slice_pkg::ADDR_W-1:0] a_addr_i,
    input wire logic [slice_pkg::ADDR_W-1:0] b_addr_i,
    input wire logic [slice_pkg::DATA_W-1:0] direct_data_i,
    input wire logic carry_i,
    input wire logic ram_lo_i,
    input wire logic ram_hi_i,
    input wire logic q_lo_i,
    input wire logic q_hi_i,
    output logic ram_lo_o,
    output logic ram_lo_oe_n_o,
    output logic ram_hi_o,
    output logic ram_hi_oe_n_o,
    output logic q_lo_o,
    output logic q_lo_oe_n_o,
    output logic q_hi_o,
    output logic q_hi_oe_n_o,
    output logic [slice_pkg::DATA_W-1:0] slice_data_output_o,
    output logic sign_o,
    output logic zero_detect_o,
    output logic carry_out_o,
    output logic arith_overflow_flag_o,
    output logic gen_n_o,
    output logic prop_n_o
);
    localparam int W = slice_pkg::DATA_W;

    ////////////////////////////////////////////////////////////////////////////
    // control word fields

    slice_pkg::src_type src;
    slice_pkg::func_type func;
    slice_pkg::dest_type dest;

    assign src = slice_pkg::src_type'(ctrl_word_i[slice_pkg::SRC_LSB +: slice_pkg::FIELD_W]);
    assign func = slice_pkg::func_type'(ctrl_word_i[slice_pkg::FUNC_LSB +: slice_pkg::FIELD_W]);
    assign dest = slice_pkg::dest_type'(ctrl_word_i[slice_pkg::DEST_LSB +: slice_pkg::FIELD_W]);

    ////////////////////////////////////////////////////////////////////////////
    // operands

    logic [W-1:0] q_reg;
    logic [W-1:0] a_word;
    logic [W-1:0] b_word;
    logic [W-1:0] r_op;
    logic [W-1:0] s_op;
    logic [W-1:0] ram_wr_data;
    logic ram_wr_en;

    // source decode looks only at its own field
    wire r_from_d = (src == slice_pkg::SRC_DA) || (src == slice_pkg::SRC_DQ)
        || (src == slice_pkg::SRC_DZ);
    wire r_from_a = (src == slice_pkg::SRC_AQ) || (src == slice_pkg::SRC_AB);
    wire s_from_q = (src == slice_pkg::SRC_AQ) || (src == slice_pkg::SRC_ZQ)
        || (src == slice_pkg::SRC_DQ);
    wire s_from_b = (src == slice_pkg::SRC_AB) || (src == slice_pkg::SRC_ZB);
    wire s_from_a = (src == slice_pkg::SRC_ZA) || (src == slice_pkg::SRC_DA);

    assign r_op = r_from_d ? direct_data_i
        : r_from_a ? a_word : slice_pkg::ZERO_WORD;
    assign s_op = s_from_q ? q_reg
        : s_from_b ? b_word
        : s_from_a ? a_word : slice_pkg::ZERO_WORD;

    slice_scratchpad u_pad (
        .sys_clk_i(sys_clk_i),
        .ce_i(ce_i),
        .wr_en_i(ram_wr_en),
        .a_addr_i(a_addr_i),
        .b_addr_i(b_addr_i),
        .wr_data_i(ram_wr_data),
        .a_word_o(a_word),
        .b_word_o(b_word)
    );

    alu_link_if lnk ();

    assign lnk.func = func;
    assign lnk.r = r_op;
    assign lnk.s = s_op;
    assign lnk.cin = carry_i;

    slice_alu_core u_alu (
        .lnk(lnk.core)
    );

    ////////////////////////////////////////////////////////////////////////////
    // destination decode

    wire [W-1:0] f = lnk.f;
    wire shift_down = (dest == slice_pkg::DST_RAMQD) || (dest == slice_pkg::DST_RAMD);
    wire shift_up = (dest == slice_pkg::DST_RAMQU) || (dest == slice_pkg::DST_RAMU);
    wire q_load = (dest == slice_pkg::DST_QREG) || (dest == slice_pkg::DST_RAMQD)
        || (dest == slice_pkg::DST_RAMQU);
    wire y_from_a = (dest == slice_pkg::DST_RAMA);
    wire q_lo_drive = shift_down;
    wire q_hi_drive = shift_up;

    assign ram_wr_en = dest >= slice_pkg::DST_RAMA;
    assign ram_wr_data = shift_down ? {ram_hi_i, f[W-1:1]}
        : shift_up ? {f[W-2:0], ram_lo_i} : f;

    wire [W-1:0] next_q = (dest == slice_pkg::DST_RAMQD) ? {q_hi_i, q_reg[W-1:1]}
        : (dest == slice_pkg::DST_RAMQU) ? {q_reg[W-2:0], q_lo_i} : f;
    wire [W-1:0] next_y = y_from_a ? a_word : f;

    ////////////////////////////////////////////////////////////////////////////
    // q register, rising edge, frozen while clock enable is low

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q_reg <= slice_pkg::Q_RESET;
        end else if (ce_i && q_load) begin
            q_reg <= next_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output stage: all outputs registered, so flags lag the control word by one edge

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            slice_data_output_o <= slice_pkg::Y_RESET;
            sign_o <= 1'b0;
            zero_detect_o <= 1'b0;
            carry_out_o <= 1'b0;
            arith_overflow_flag_o <= 1'b0;
            gen_n_o <= 1'b1;
            prop_n_o <= 1'b1;
        end else if (ce_i) begin
            slice_data_output_o <= next_y;
            sign_o <= f[W-1];
            zero_detect_o <= (f == slice_pkg::ZERO_WORD);
            carry_out_o <= lnk.cout;
            arith_overflow_flag_o <= lnk.arith_overflow_flag;
            gen_n_o <= lnk.gen_n;
            prop_n_o <= lnk.prop_n;
        end
    end

    // shift pins: enable low while driving; a neighbour sees them one edge late
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ram_lo_o <= 1'b0;
            ram_hi_o <= 1'b0;
            q_lo_o <= 1'b0;
            q_hi_o <= 1'b0;
            ram_lo_oe_n_o <= 1'b1;
            ram_hi_oe_n_o <= 1'b1;
            q_lo_oe_n_o <= 1'b1;
            q_hi_oe_n_o <= 1'b1;
        end else if (ce_i) begin
            ram_lo_o <= f[0];
            ram_hi_o <= f[W-1];
            q_lo_o <= q_reg[0];
            q_hi_o <= q_reg[W-1];
            ram_lo_oe_n_o <= !shift_down;
            ram_hi_oe_n_o <= !shift_up;
            q_lo_oe_n_o <= !q_lo_drive;
            q_hi_oe_n_o <= !q_hi_drive;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    property p_r_mux;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (src >= slice_pkg::SRC_DA) |-> (r_op == direct_data_i);
    endproperty
    a_r_mux: assert property (p_r_mux) else $error("r operand not direct data");

    property p_s_mux;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (src == slice_pkg::SRC_AB) |-> (s_op == b_word && r_op == a_word);
    endproperty
    a_s_mux: assert property (p_s_mux) else $error("a,b pair wrong");

    property p_zero_src;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (src inside {slice_pkg::SRC_ZQ, slice_pkg::SRC_ZB, slice_pkg::SRC_ZA})
            |-> (r_op == 4'h0);
    endproperty
    a_zero_src: assert property (p_zero_src) else $error("zero source not zero");

    property p_add;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (func == slice_pkg::FN_ADD) |-> (f == 4'(r_op + s_op + {3'h0, carry_i}));
    endproperty
    a_add: assert property (p_add) else $error("add result wrong");

    property p_logic_carry;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (func == slice_pkg::FN_XOR) |-> (f == (r_op ^ s_op) && !lnk.cout && !lnk.arith_overflow_flag);
    endproperty
    a_logic_carry: assert property (p_logic_carry) else $error("logic used carry");

    property p_ovr;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (ce_i && func == slice_pkg::FN_ADD && r_op == 4'h7 && s_op == 4'h1 && !carry_i)
            |=> arith_overflow_flag_o && !carry_out_o;
    endproperty
    a_ovr: assert property (p_ovr) else $error("overflow missed");

    property p_zero;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        ce_i |=> (zero_detect_o == ($past(f) == 4'h0));
    endproperty
    a_zero: assert property (p_zero) else $error("zero detect wrong");

    sequence s_q_load_cmd;
        ce_i && dest == slice_pkg::DST_QREG;
    endsequence

    property p_q_load;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        s_q_load_cmd |=> (q_reg == $past(f))
            ##1 (!$past(ce_i) || $past(q_load) || $stable(q_reg));
    endproperty
    a_q_load: assert property (p_q_load) else $error("q load failed");

    property p_q_shift;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (ce_i && dest == slice_pkg::DST_RAMQD)
            |=> (q_reg == {$past(q_hi_i), $past(q_reg[W-1:1])}) && !q_lo_oe_n_o;
    endproperty
    a_q_shift: assert property (p_q_shift) else $error("q shift down wrong");

    property p_y_sel;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (ce_i && dest == slice_pkg::DST_RAMA) |=> (slice_data_output_o == $past(a_word));
    endproperty
    a_y_sel: assert property (p_y_sel) else $error("a-port not on output");

    property p_freeze;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        !ce_i |=> $stable(q_reg) && $stable(slice_data_output_o) && $stable(zero_detect_o);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");

    property p_logic_flags;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (func >= slice_pkg::FN_OR) |-> (!lnk.cout && !lnk.arith_overflow_flag && lnk.gen_n && lnk.prop_n);
    endproperty
    a_logic_flags: assert property (p_logic_flags) else $error("logic flags not idle");

    property p_s_minus_r;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (func == slice_pkg::FN_S_MINUS_R) |-> (f == 4'(s_op + ~r_op + {3'h0, carry_i}));
    endproperty
    a_s_minus_r: assert property (p_s_minus_r) else $error("s minus r wrong");

    property p_r_minus_s;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (func == slice_pkg::FN_R_MINUS_S) |-> (f == 4'(r_op + ~s_op + {3'h0, carry_i}));
    endproperty
    a_r_minus_s: assert property (p_r_minus_s) else $error("r minus s wrong");

    property p_cout;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (func == slice_pkg::FN_ADD)
            |-> (lnk.cout == ((5'(r_op) + 5'(s_op) + 5'(carry_i)) > 5'h0f));
    endproperty
    a_cout: assert property (p_cout) else $error("carry out wrong");

    property p_ram_down;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (dest == slice_pkg::DST_RAMQD || dest == slice_pkg::DST_RAMD)
            |-> (ram_wr_en && ram_wr_data == {ram_hi_i, f[W-1:1]});
    endproperty
    a_ram_down: assert property (p_ram_down) else $error("ram shift down wrong");

    property p_ram_up;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (dest == slice_pkg::DST_RAMQU || dest == slice_pkg::DST_RAMU)
            |-> (ram_wr_en && ram_wr_data == {f[W-2:0], ram_lo_i});
    endproperty
    a_ram_up: assert property (p_ram_up) else $error("ram shift up wrong");

    property p_no_write;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (dest < slice_pkg::DST_RAMA) |-> !ram_wr_en;
    endproperty
    a_no_write: assert property (p_no_write) else $error("scratchpad written");

    property p_q_up;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (ce_i && dest == slice_pkg::DST_RAMQU)
            |=> (q_reg == {$past(q_reg[W-2:0]), $past(q_lo_i)}) && !q_hi_oe_n_o;
    endproperty
    a_q_up: assert property (p_q_up) else $error("q shift up wrong");

    property p_oe_idle;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (ce_i && dest < slice_pkg::DST_RAMQD)
            |=> (ram_lo_oe_n_o && ram_hi_oe_n_o && q_lo_oe_n_o && q_hi_oe_n_o);
    endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("shift pin driven");

    property p_q_feed;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        s_q_load_cmd ##1 s_from_q |-> (s_op == $past(f));
    endproperty
    a_q_feed: assert property (p_q_feed) else $error("q not fed back");

endmodule

//--- include/slice_pkg.sv
// Behaviour
// - r operand muxes direct data or a-port
// - s operand from a-port, b-port or q
// - source field picks one of eight pairs
// - function field picks one of eight operations
// - nine control bits steer source, function, destination
// - result to q, scratchpad or output mux
// - carry input ignored by logical functions
// - arithmetic adds carry input to result
// - generate, propagate, carry-out, overflow for add/sub
// - q loads, shifts left/right, feeds s operand
// - source decode independent of function decode
// - overflow when msb carry in/out differ
// - zero detect when all result bits zero
// - q register loads on rising clock
// - bits six to eight pick destination code
package slice_pkg;

    localparam int DATA_W = 4;
    localparam int ADDR_W = 4;
    localparam int WORDS = 16;
    localparam int CTRL_W = 9;

    // control word field positions
    localparam int SRC_LSB = 0;
    localparam int FUNC_LSB = 3;
    localparam int DEST_LSB = 6;
    localparam int FIELD_W = 3;

    localparam logic [DATA_W-1:0] ZERO_WORD = 4'h0;
    localparam logic [DATA_W-1:0] Q_RESET = 4'h0;
    localparam logic [DATA_W-1:0] Y_RESET = 4'h0;

    typedef enum logic [2:0] {
        SRC_AQ = 3'b000,
        SRC_AB = 3'b001,
        SRC_ZQ = 3'b010,
        SRC_ZB = 3'b011,
        SRC_ZA = 3'b100,
        SRC_DA = 3'b101,
        SRC_DQ = 3'b110,
        SRC_DZ = 3'b111
    } src_type;

    typedef enum logic [2:0] {
        FN_ADD = 3'b000,
        FN_S_MINUS_R = 3'b001,
        FN_R_MINUS_S = 3'b010,
        FN_OR = 3'b011,
        FN_AND = 3'b100,
        FN_NOTR_AND = 3'b101,
        FN_XOR = 3'b110,
        FN_XNOR = 3'b111
    } func_type;

    typedef enum logic [2:0] {
        DST_QREG = 3'b000,
        DST_NOP = 3'b001,
        DST_RAMA = 3'b010,
        DST_RAMF = 3'b011,
        DST_RAMQD = 3'b100,
        DST_RAMD = 3'b101,
        DST_RAMQU = 3'b110,
        DST_RAMU = 3'b111
    } dest_type;

    function automatic logic is_logic(input func_type fn);
        return fn >= FN_OR;
    endfunction

endpackage

//--- include/alu_link_if.sv
`timescale 1ns/1ns
interface alu_link_if;
    slice_pkg::func_type func;
    logic [slice_pkg::DATA_W-1:0] r;
    logic [slice_pkg::DATA_W-1:0] s;
    logic cin;
    logic [slice_pkg::DATA_W-1:0] f;
    logic gen_n;
    logic prop_n;
    logic cout;
    logic arith_overflow_flag;

    modport core (input func, input r, input s, input cin,
                  output f, output gen_n, output prop_n, output cout, output arith_overflow_flag);
    modport user (output func, output r, output s, output cin,
                  input f, input gen_n, input prop_n, input cout, input arith_overflow_flag);
endinterface

//--- design/slice_scratchpad.sv
`timescale 1ns/1ns
module slice_scratchpad (
    input wire logic sys_clk_i,
    input wire logic ce_i,
    input wire logic wr_en_i,
    input wire logic [slice_pkg::ADDR_W-1:0] a_addr_i,
    input wire logic [slice_pkg::ADDR_W-1:0] b_addr_i,
    input wire logic [slice_pkg::DATA_W-1:0] wr_data_i,
    output logic [slice_pkg::DATA_W-1:0] a_word_o,
    output logic [slice_pkg::DATA_W-1:0] b_word_o
);
    logic [slice_pkg::DATA_W-1:0] mem [slice_pkg::WORDS];

    // read before write: both ports show the old word until the edge
    assign a_word_o = mem[a_addr_i];
    assign b_word_o = mem[b_addr_i];

    // storage has no reset, contents are undefined until written
    always_ff @(posedge sys_clk_i) begin
        if (ce_i && wr_en_i) begin
            mem[b_addr_i] <= wr_data_i;
        end
    end
endmodule

//--- design/slice_alu_core.sv
`timescale 1ns/1ns
module slice_alu_core (
    alu_link_if.core lnk
);
    localparam int W = slice_pkg::DATA_W;

    wire sub_r = (lnk.func == slice_pkg::FN_S_MINUS_R);
    wire sub_s = (lnk.func == slice_pkg::FN_R_MINUS_S);
    wire [W-1:0] r_eff = sub_r ? ~lnk.r : lnk.r;
    wire [W-1:0] s_eff = sub_s ? ~lnk.s : lnk.s;
    wire [W:0] sum = {1'b0, r_eff} + {1'b0, s_eff} + {{W{1'b0}}, lnk.cin};
    wire [W-1:0] low = {1'b0, r_eff[W-2:0]} + {1'b0, s_eff[W-2:0]} + {{(W-1){1'b0}}, lnk.cin};
    wire [W-1:0] gen_bit;
    wire [W-1:0] prop_bit;
    wire arith = !slice_pkg::is_logic(lnk.func);
    logic [W-1:0] logic_f;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_gp
            assign gen_bit[i] = r_eff[i] & s_eff[i];
            assign prop_bit[i] = r_eff[i] | s_eff[i];
        end
    endgenerate

    wire group_gen = gen_bit[3] | (prop_bit[3] & gen_bit[2])
        | (prop_bit[3] & prop_bit[2] & gen_bit[1])
        | (prop_bit[3] & prop_bit[2] & prop_bit[1] & gen_bit[0]);

    always_comb begin
        case (lnk.func)
            slice_pkg::FN_OR: logic_f = lnk.r | lnk.s;
            slice_pkg::FN_AND: logic_f = lnk.r & lnk.s;
            slice_pkg::FN_NOTR_AND: logic_f = ~lnk.r & lnk.s;
            slice_pkg::FN_XOR: logic_f = lnk.r ^ lnk.s;
            slice_pkg::FN_XNOR: logic_f = ~(lnk.r ^ lnk.s);
            default: logic_f = slice_pkg::ZERO_WORD;
        endcase
    end

    // logic path never looks at the carry input
    assign lnk.f = arith ? sum[W-1:0] : logic_f;
    assign lnk.cout = arith & sum[W];
    assign lnk.arith_overflow_flag = arith & (low[W-1] ^ sum[W]);
    assign lnk.gen_n = arith ? ~group_gen : 1'b1;
    assign lnk.prop_n = arith ? ~(&prop_bit) : 1'b1;
endmodule

//--- dv/ctrl_sequencer_model.sv
`timescale 1ns/1ns
module ctrl_sequencer_model (
    input wire logic sys_clk_i,
    output logic [slice_pkg::CTRL_W-1:0] ctrl_word_o,
    output logic ce_o
);
    ////////////////////////////////////////////////////////////////////////////////
    // idle word until the first issue; enable low keeps the slice frozen
    initial begin
        ctrl_word_o = 9'h000;
        ce_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one microinstruction per cycle, changed only on the falling edge
    task automatic issue(input logic [slice_pkg::CTRL_W-1:0] word, input logic en);
        @(negedge sys_clk_i);
        ctrl_word_o = word;
        ce_o = en;
    endtask
endmodule

//--- dv/bitslice_alu_source_function_tb.sv
`timescale 1ns/1ns
module bitslice_alu_source_function_tb;
    logic sys_clk_i, resetn_i, ce_i, carry_i, ram_lo_i, ram_hi_i, q_lo_i, q_hi_i;
    logic [slice_pkg::CTRL_W-1:0] ctrl_word_i;
    logic [3:0] a_addr_i, b_addr_i, direct_data_i, slice_data_output_o;
    logic ram_lo_o, ram_lo_oe_n_o, ram_hi_o, ram_hi_oe_n_o, q_lo_o, q_lo_oe_n_o, q_hi_o;
    logic q_hi_oe_n_o, sign_o, zero_detect_o, carry_out_o, arith_overflow_flag_o, gen_n_o;
    logic prop_n_o;
    int errors, samples_checked, cycles;
    logic [31:0] lfsr;
    logic [3:0] ram [16];
    logic [15:0] valid;
    logic [3:0] q, ey, eflag, eoe, esh;
    logic [1:0] egp;
    logic fix_en;
    logic [4:0] fix_val;

    ctrl_sequencer_model seq (.sys_clk_i(sys_clk_i), .ctrl_word_o(ctrl_word_i), .ce_o(ce_i));

    bitslice_alu_source_function dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
        .ce_i(ce_i), .ctrl_word_i(ctrl_word_i), .a_addr_i(a_addr_i), .b_addr_i(b_addr_i),
        .direct_data_i(direct_data_i), .carry_i(carry_i), .ram_lo_i(ram_lo_i),
        .ram_hi_i(ram_hi_i), .q_lo_i(q_lo_i), .q_hi_i(q_hi_i), .ram_lo_o(ram_lo_o),
        .ram_lo_oe_n_o(ram_lo_oe_n_o), .ram_hi_o(ram_hi_o), .ram_hi_oe_n_o(ram_hi_oe_n_o),
        .q_lo_o(q_lo_o), .q_lo_oe_n_o(q_lo_oe_n_o), .q_hi_o(q_hi_o), .q_hi_oe_n_o(q_hi_oe_n_o),
        .slice_data_output_o(slice_data_output_o), .sign_o(sign_o),
        .zero_detect_o(zero_detect_o), .carry_out_o(carry_out_o),
        .arith_overflow_flag_o(arith_overflow_flag_o), .gen_n_o(gen_n_o), .prop_n_o(prop_n_o));

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    // ceiling well above the ~2800 cycles the sequence needs
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 4000) begin
            errors++;
            complete_run();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction

    // returns {gen_n, prop_n, ovr, cout, f}
    function automatic logic [7:0] alu_ref(input logic [2:0] fn, input logic [3:0] r,
                                           input logic [3:0] s, input logic c);
        logic [3:0] x, y, p, g;
        logic [4:0] sum;
        x = (fn == 3'h1) ? ~r : r;
        y = (fn == 3'h2) ? ~s : s;
        sum = {1'b0, x} + {1'b0, y} + {4'h0, c};
        p = x | y;
        g = x & y;
        case (fn)
            3'h0, 3'h1, 3'h2: return {~(g[3] | p[3] & g[2] | &p[3:2] & g[1] | &p[3:1] & g[0]),
                ~&p, x[3] ^ y[3] ^ sum[3] ^ sum[4], sum[4], sum[3:0]};
            3'h3: return {4'hc, r | s};
            3'h4: return {4'hc, r & s};
            3'h5: return {4'hc, ~r & s};
            3'h6: return {4'hc, r ^ s};
            default: return {4'hc, ~(r ^ s)};
        endcase
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cmp_all();
        check({4'h0, slice_data_output_o}, {4'h0, ey});
        check({4'h0, sign_o, zero_detect_o, carry_out_o, arith_overflow_flag_o}, {4'h0, eflag});
        check({6'h0, gen_n_o, prop_n_o}, {6'h0, egp});
        check({4'h0, ram_lo_oe_n_o, ram_hi_oe_n_o, q_lo_oe_n_o, q_hi_oe_n_o}, {4'h0, eoe});
        check({4'h0, ram_lo_o, ram_hi_o, q_lo_o, q_hi_o} | {4'h0, eoe}, {4'h0, esh | eoe});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic step(input logic [8:0] w, input logic en);
        logic [3:0] a, b, r, s, f;
        logic [7:0] res;
        logic [31:0] v;
        v = rnd();
        seq.issue(w, en);
        a_addr_i = v[3:0];
        b_addr_i = v[7:4];
        // corners pin direct data and carry, the rest stays random
        direct_data_i = fix_en ? fix_val[3:0] : v[11:8];
        {carry_i, ram_lo_i, ram_hi_i, q_lo_i, q_hi_i} = {fix_en ? fix_val[4] : v[16], v[15:12]};
        a = ram[a_addr_i];
        b = ram[b_addr_i];
        case (w[2:0])
            3'h0: {r, s} = {a, q};
            3'h1: {r, s} = {a, b};
            3'h2: {r, s} = {4'h0, q};
            3'h3: {r, s} = {4'h0, b};
            3'h4: {r, s} = {4'h0, a};
            3'h5: {r, s} = {direct_data_i, a};
            3'h6: {r, s} = {direct_data_i, q};
            default: {r, s} = {direct_data_i, 4'h0};
        endcase
        if (en) begin
            res = alu_ref(w[5:3], r, s, carry_i);
            f = res[3:0];
            ey = (w[8:6] == 3'h2) ? a : f;
            eflag = {f[3], f == 4'h0, res[4], res[5]};
            egp = res[7:6];
            eoe = {w[8:7] != 2'b10, w[8:7] != 2'b11, w[8:7] != 2'b10, w[8:7] != 2'b11};
            esh = {f[0], f[3], q[0], q[3]};
            if (w[8:6] >= 3'h2) valid[b_addr_i] = 1'b1;
            case (w[8:6])
                3'h0: q = f;
                3'h2, 3'h3: ram[b_addr_i] = f;
                3'h4, 3'h5: ram[b_addr_i] = {ram_hi_i, f[3:1]};
                3'h6, 3'h7: ram[b_addr_i] = {f[2:0], ram_lo_i};
                default: ;
            endcase
            if (w[8:6] == 3'h4) q = {q_hi_i, q[3:1]};
            if (w[8:6] == 3'h6) q = {q[2:0], q_lo_i};
        end
        @(posedge sys_clk_i);
        #1;
        cmp_all();
    endtask

    task automatic do_reset(input int n);
        // freeze first: a live word would write the scratchpad under reset
        seq.issue(9'o337, 1'b0);
        resetn_i = 1'b0;
        repeat (n) @(negedge sys_clk_i);
        resetn_i = 1'b1;
        q = 4'h0;
        ey = 4'h0;
        eflag = 4'h0;
        egp = 2'h3;
        eoe = 4'hf;
        esh = 4'h0;
        cmp_all();
    endtask

    task automatic complete_run();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        lfsr = 32'he27321a3;
        {errors, samples_checked, cycles} = '0;
        {resetn_i, carry_i, ram_lo_i, ram_hi_i, q_lo_i, q_hi_i} = '0;
        {a_addr_i, b_addr_i, direct_data_i} = '0;
        valid = 16'h0000;
        fix_en = 1'b0;
        fix_val = 5'h00;
        do_reset(5);
        // scratchpad powers up unknown: pass d into every word first
        for (int i = 0; i < 400 && valid != 16'hffff; i++) begin
            step(9'o337, 1'b1);
        end
        // corners: q = 1, then 7 + q overflows, then f + q + 1 wraps with carry
        fix_en = 1'b1;
        fix_val = 5'h01;
        step(9'o037, 1'b1);
        fix_val = 5'h07;
        step(9'o106, 1'b1);
        fix_val = 5'h1f;
        step(9'o106, 1'b1);
        fix_en = 1'b0;
        for (int i = 0; i < 512; i++) begin
            step(i[8:0], 1'b1);
        end
        for (int i = 0; i < 2000; i++) begin
            step(9'(rnd() >> 7), lfsr[3:1] != 3'h0);
        end
        // reset mid-run clears q but leaves the scratchpad intact
        do_reset(2);
        for (int i = 0; i < 200; i++) begin
            step(9'(rnd() >> 3), 1'b1);
        end
        complete_run();
    end
endmodule
